// file: logic/prs_i2c_slave.sv
// two-wire register slave port: bus side on the bus clock, register side on clk
// assumes an open-drain data wire resolved outside, and a register array on the
// system side that answers a read request combinationally in the same cycle
// Behaviour
// RULE1: slave only, bus clock shifts all bits
// RULE2: data line received and driven, open drain
// RULE3: every byte travels most significant first
// RULE4: master sends start, address, direction bit
// RULE5: direction one reads, zero writes
// RULE6: answer only first bytes 5c and 5d
// RULE7: acknowledge each byte at own address
// RULE8: second byte is register index, acknowledged
// RULE9: one data byte last, then final acknowledge
// RULE10: spike filter on data before sampling
// RULE11: bus rate at most 400 kbit/s
// RULE12: no auto increment, one byte per transfer
// RULE13: master writes index 1f before 1e
// RULE14: read returns selected register, master nacks
`timescale 1ns/1ps
`default_nettype none
module prs_i2c_slave
   import prs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic wr_req,
   output prs_wr_s wr,
   output logic rd_req,
   output logic [7:0] rd_index,
   input wire logic [7:0] rd_data,
   output logic frame_active
);

   // ==========================================================
   // system side: synchronisers and data filter
   logic scl_s1, scl_s2, sda_s1, sda_s2;
   logic sda_filt, sda_filt_d, next_sda_filt;
   logic [FILT_W-1:0] filt_cnt, next_filt_cnt;
   logic start_pend, next_start_pend, link_run, next_link_run;
   logic wr_t1, wr_t2, wr_t3, rd_t1, rd_t2, rd_t3;
   logic next_wr_req, next_rd_req;
   prs_wr_s next_wr;
   logic [7:0] next_rd_index, rd_hold, next_rd_hold;

   // link side state
   prs_state_e state, next_state;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic [7:0] shift, next_shift, byte_now;
   logic in_ack, next_in_ack, ack_drive, next_ack_drive;
   logic [7:0] link_index, next_link_index, link_wdata, next_link_wdata;
   logic wr_tgl, next_wr_tgl, rd_tgl, next_rd_tgl;
   logic [7:0] rd_shift, next_rd_shift;
   logic next_oe;

   // both pins reset to their idle high level so that the release of reset
   // never looks like a falling data edge with the clock high (a false start)
   // the first synchroniser stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         wr_t1 <= 1'b0;
         wr_t2 <= 1'b0;
         wr_t3 <= 1'b0;
         rd_t1 <= 1'b0;
         rd_t2 <= 1'b0;
         rd_t3 <= 1'b0;
      end else begin
         scl_s1 <= scl;
         scl_s2 <= scl_s1;
         sda_s1 <= sda_i;
         sda_s2 <= sda_s1;
         wr_t1 <= wr_tgl;
         wr_t2 <= wr_t1;
         wr_t3 <= wr_t2;
         rd_t1 <= rd_tgl;
         rd_t2 <= rd_t1;
         rd_t3 <= rd_t2;
      end
   end

   // filter: a new level must persist FILT_CYC cycles; lag stays under data setup
   // a spike shorter than the window restarts the count and never reaches the
   // output; the price is a fixed lag of about 15 system clocks on every data edge,
   // which the master's data setup time must cover at the fastest bus rate
   always_comb begin
      next_sda_filt = sda_filt;
      next_filt_cnt = FILT_ZERO;
      if (sda_s2 != sda_filt) begin // RULE10
         if (filt_cnt == FILT_LAST) begin
            next_sda_filt = sda_s2;
         end else begin
            next_filt_cnt = filt_cnt + FILT_ONE; // RULE11
         end
      end
   end

   // start and stop seen while the clock is high; the link logic is held in reset
   // between frames and released only once the clock is low after a start
   // a data edge that the filter delays past a clock edge could pass for a start
   // or stop; this is safe only while data setup stays above the filter lag
   always_comb begin
      next_start_pend = start_pend;
      next_link_run = link_run;
      if (scl_s2 && sda_filt_d && !sda_filt) begin
         next_start_pend = 1'b1; // RULE4
         next_link_run = 1'b0;
      end else if (scl_s2 && !sda_filt_d && sda_filt) begin
         next_start_pend = 1'b0;
         next_link_run = 1'b0;
      end else if (start_pend && !scl_s2) begin
         next_start_pend = 1'b0;
         next_link_run = 1'b1;
      end
   end

   // events from the link arrive as toggles; link registers are stable by then
   // the chain leaves two clean flops before the edge compare; the word travels
   // beside the toggle and is read only once the toggle has settled
   always_comb begin
      next_wr_req = wr_t3 ^ wr_t2;
      next_rd_req = rd_t3 ^ rd_t2;
      next_wr = wr;
      next_rd_index = rd_index;
      next_rd_hold = rd_hold;
      if (wr_t3 ^ wr_t2) begin
         next_wr.index = link_index; // RULE9
         next_wr.data = link_wdata;
      end
      if (rd_t3 ^ rd_t2) begin
         next_rd_index = link_index; // RULE14
      end
      if (rd_req) begin
         next_rd_hold = rd_data; // RULE14
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_filt <= 1'b1;
         sda_filt_d <= 1'b1;
         filt_cnt <= FILT_ZERO;
         start_pend <= 1'b0;
         link_run <= 1'b0;
         wr_req <= 1'b0;
         rd_req <= 1'b0;
         wr <= '0;
         rd_index <= 8'h00;
         rd_hold <= 8'h00;
      end else begin
         sda_filt <= next_sda_filt;
         sda_filt_d <= sda_filt;
         filt_cnt <= next_filt_cnt;
         start_pend <= next_start_pend;
         link_run <= next_link_run;
         wr_req <= next_wr_req;
         rd_req <= next_rd_req;
         wr <= next_wr;
         rd_index <= next_rd_index;
         rd_hold <= next_rd_hold;
      end
   end

   // the pad is shared with the master: sda_i is the wired result of both sides
   assign frame_active = link_run;
   assign sda_o = 1'b0; // open drain: only ever pulls low

   // ==========================================================
   // link side, rising bus clock: sample and decode
   // limitation: a master that moves data later than the filter lag before the
   // rising clock edge will have its bit taken at the old level
   // sda_filt is read directly: the master holds it steady over the rising edge
   // for longer than the filter lag, so no metastable window is sampled
   always_comb begin
      byte_now = {shift[6:0], sda_filt}; // RULE3
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shift = shift;
      next_in_ack = in_ack;
      next_ack_drive = ack_drive;
      next_link_index = link_index;
      next_link_wdata = link_wdata;
      next_wr_tgl = wr_tgl;
      next_rd_tgl = rd_tgl;
      if (in_ack) begin
         // ninth bit slot: master samples our ack or gives its own
         next_in_ack = 1'b0;
         next_ack_drive = 1'b0;
         next_bit_cnt = FIRST_BIT;
      end else begin
         next_shift = byte_now;
         next_bit_cnt = bit_cnt + 3'h1; // RULE1
         if (bit_cnt == LAST_BIT) begin
            next_in_ack = 1'b1;
            case (state)
               ST_ADDR: begin
                  if (byte_now == DEV_WR_ID) begin // RULE6
                     next_ack_drive = 1'b1; // RULE7
                     next_state = ST_INDEX; // RULE5
                  end else if (byte_now == DEV_RD_ID && byte_now[RW_POS]) begin
                     next_ack_drive = 1'b1; // RULE7
                     next_state = ST_RDATA; // RULE5
                     next_rd_tgl = ~rd_tgl;
                  end else begin
                     next_state = ST_DONE; // RULE6
                  end
               end
               ST_INDEX: begin
                  next_ack_drive = 1'b1; // RULE8
                  next_link_index = byte_now; // RULE8
                  next_state = ST_WDATA;
               end
               ST_WDATA: begin
                  next_ack_drive = 1'b1; // RULE9
                  next_link_wdata = byte_now;
                  next_wr_tgl = ~wr_tgl;
                  next_state = ST_DONE; // RULE12
               end
               ST_RDATA: begin
                  next_state = ST_DONE; // RULE14
               end
               default: begin
                  // further bytes are not acknowledged and not stored
                  next_state = ST_DONE; // RULE12
               end
            endcase
         end
      end
   end

   // frame state: cleared by every start and stop through link_run
   // the async clear comes from the system side; it is released only while the
   // bus clock is low, so the first rising edge finds the flops out of reset
   always_ff @(posedge scl or negedge link_run) begin
      if (!link_run) begin
         state <= ST_ADDR;
         bit_cnt <= FIRST_BIT;
         shift <= 8'h00;
         in_ack <= 1'b0;
         ack_drive <= 1'b0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shift <= next_shift;
         in_ack <= next_in_ack;
         ack_drive <= next_ack_drive;
      end
   end

   // index and toggles survive frame ends so a later read finds the index
   // kept outside the frame reset on purpose: a read frame carries no index
   always_ff @(posedge scl or negedge rst_n) begin
      if (!rst_n) begin
         link_index <= 8'h00;
         link_wdata <= 8'h00;
         wr_tgl <= 1'b0;
         rd_tgl <= 1'b0;
      end else begin
         link_index <= next_link_index;
         link_wdata <= next_link_wdata;
         wr_tgl <= next_wr_tgl;
         rd_tgl <= next_rd_tgl;
      end
   end

   // ==========================================================
   // link side, falling bus clock: drive ack and read bits
   // the first read bit comes from rd_hold, later ones from the local shifter,
   // so rd_hold only needs to be quiet at one falling edge per read
   // rd_hold was loaded over a whole bit time earlier, so it is quiet here
   always_comb begin
      next_oe = 1'b0;
      next_rd_shift = rd_shift;
      if (ack_drive) begin
         next_oe = 1'b1; // RULE7
      end else if (state == ST_RDATA && !in_ack) begin
         if (bit_cnt == FIRST_BIT) begin
            next_oe = ~rd_hold[7]; // RULE14
            next_rd_shift = {rd_hold[6:0], 1'b0};
         end else begin
            next_oe = ~rd_shift[7]; // RULE3
            next_rd_shift = {rd_shift[6:0], 1'b0};
         end
      end
   end

   always_ff @(negedge scl or negedge link_run) begin
      if (!link_run) begin
         sda_oe <= 1'b0;
         rd_shift <= 8'h00;
      end else begin
         sda_oe <= next_oe; // RULE2
         rd_shift <= next_rd_shift;
      end
   end

endmodule : prs_i2c_slave
`default_nettype wire

// file: logic/prs_pkg.sv
// package for the two-wire register slave of the power management unit
// assumes a 250 MHz system clock; the bus clock comes from the external master
package prs_pkg;
   // ==========================================================
   // slave identity on the bus (first byte, direction bit in bit 0)
   localparam logic [7:0] DEV_WR_ID = 8'h5c;
   localparam logic [7:0] DEV_RD_ID = 8'h5d;
   localparam int RW_POS = 0;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [2:0] FIRST_BIT = 3'h0;
   // ==========================================================
   // timing: spike filter on the data line
   localparam int CLK_PERIOD_PS = 4000;
   localparam int SPIKE_REJECT_NS = 50;
   localparam int FILT_CYC = (SPIKE_REJECT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int FILT_W = 4;
   localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYC - 1);
   localparam logic [FILT_W-1:0] FILT_ZERO = 4'h0;
   localparam logic [FILT_W-1:0] FILT_ONE = 4'h1;
   // fastest bus the filter lag was budgeted against (lag must stay under data setup)
   localparam int SCL_MAX_KHZ = 400;
   localparam int DATA_SETUP_NS = 100;
   // ==========================================================
   // link-side transfer phases
   typedef enum logic [2:0] {
      ST_ADDR = 3'b000,
      ST_INDEX = 3'b001,
      ST_WDATA = 3'b010,
      ST_RDATA = 3'b011,
      ST_DONE = 3'b100
   } prs_state_e;
   // one register write handed to the system side
   typedef struct packed {
      logic [7:0] index;
      logic [7:0] data;
   } prs_wr_s;
endpackage : prs_pkg

// file: verification/prs_i2c_slave_sva.sv
// checker for the two-wire register slave port, watching its top-level pins
// assumes every relation here is sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module prs_i2c_slave_chk
   import prs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic wr_req,
   input wire prs_wr_s wr,
   input wire logic rd_req,
   input wire logic frame_active
);
   // ==========================================================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // requests are single pulses followed by at least eight quiet system clocks
   sequence s_quiet_wr;
      !wr_req [*8];
   endsequence
   sequence s_quiet_rd;
      !rd_req [*8];
   endsequence
   property p_sda_o;
      sda_o == 1'b0;
   endproperty
   property p_oe_rise;
      $rose(sda_oe) |-> !scl && frame_active;
   endproperty
   property p_oe_fall;
      $fell(sda_oe) |-> !scl;
   endproperty
   property p_wr_pulse;
      wr_req |=> s_quiet_wr;
   endproperty
   property p_rd_pulse;
      rd_req |=> s_quiet_rd;
   endproperty
   property p_wr_cause;
      $changed(wr) |-> wr_req;
   endproperty
   property p_frame_start;
      $rose(frame_active) |-> !scl;
   endproperty
   property p_req_in_frame;
      (wr_req || rd_req) |-> frame_active;
   endproperty
   a_sda_o: assert property (p_sda_o) else $error("data pin driven high");
   a_oe_rise: assert property (p_oe_rise) else $error("drive began off clock low");
   a_oe_fall: assert property (p_oe_fall) else $error("drive ended off clock low");
   a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
   a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse too long");
   a_wr_cause: assert property (p_wr_cause) else $error("word moved without pulse");
   a_frame_start: assert property (p_frame_start) else $error("frame opened wrongly");
   a_req_in_frame: assert property (p_req_in_frame) else $error("request outside frame");
endmodule : prs_i2c_slave_chk
bind prs_i2c_slave prs_i2c_slave_chk prs_i2c_slave_chk_i (.clk, .rst_n, .scl, .sda_o, .sda_oe,
   .wr_req, .wr, .rd_req, .frame_active);
`default_nettype wire

// file: verification/prs_host_model.sv
// bus master model: makes the bus clock and pulls the data wire low
// assumes the bench resolves the open-drain wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module prs_host_model (
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   // ==========================================================
   // clock stands high and data released between frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // start: data falls with clock high, held well past the filter lag
   task automatic start();
      #13 sda_low = 1'b1;
      #160 scl = 1'b0;
   endtask : start
   // one 160 ns bit cell; data moves as the clock falls (zero hold is legal) so the
   // slave's filter lag is over well before the rise
   task automatic wbit(input logic b, output logic r);
      sda_low = ~b;
      #80 scl = 1'b1;
      #40 r = sda;
      #40 scl = 1'b0;
   endtask : wbit
   // byte most significant first, ninth bit with the wire released
   task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         wbit(d[i], q[i]);
      end
      wbit(1'b1, ack);
   endtask : xfer
   // stop: data rises with clock high
   task automatic stop();
      sda_low = 1'b1;
      #80 scl = 1'b1;
      #80 sda_low = 1'b0;
      #80;
   endtask : stop
   // glitch far shorter than the filter that straddles a clock fall: unfiltered,
   // it would pass for a start and open a frame; the clock is left low
   task automatic spike();
      #13 sda_low = 1'b1;
      #10 scl = 1'b0;
      #10 sda_low = 1'b0;
   endtask : spike
   // clock back to its idle high level with data released
   task automatic idle();
      #80 scl = 1'b1;
      #80;
   endtask : idle
endmodule : prs_host_model
`default_nettype wire

// file: verification/prs_i2c_slave_tb_top.sv
// self-checking bench for the two-wire register slave port
// assumes the host model owns the bus; the wire has a pull-up
`timescale 1ns/1ps
`default_nettype none
module prs_i2c_slave_tb_top;
   import prs_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] rd_data = 8'h00;
   logic scl, host_low, sda_i, sda_o, sda_oe, wr_req, rd_req, frame_active;
   logic [7:0] rd_index, last_idx, q;
   logic a0, a1, a2, a3;
   prs_wr_s wr, last_wr;
   int errors = 0;
   int n_checks = 0;
   int n_wr = 0;
   int n_rd = 0;
   int n0;
   always #2 clk = ~clk;
   // ==========================================================
   // open-drain wire: low while either side pulls
   assign sda_i = !(host_low || sda_oe);
   prs_host_model prs_host_model_i (.scl(scl), .sda_low(host_low), .sda(sda_i));
   prs_i2c_slave prs_i2c_slave_i (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_i),
      .sda_o(sda_o), .sda_oe(sda_oe), .wr_req(wr_req), .wr(wr), .rd_req(rd_req),
      .rd_index(rd_index), .rd_data(rd_data), .frame_active(frame_active));
   // count system-side pulses and keep what they carried
   always @(posedge clk) begin
      if (wr_req === 1'b1) begin
         n_wr <= n_wr + 1;
         last_wr <= wr;
      end
      if (rd_req === 1'b1) begin
         n_rd <= n_rd + 1;
         last_idx <= rd_index;
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic final_report();
      if (errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report
   // ==========================================================
   // scenarios
   task automatic t_write(input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk);
      n0 = n_wr;
      prs_host_model_i.start();
      prs_host_model_i.xfer(DEV_WR_ID, q, a0);
      prs_host_model_i.xfer(idx, q, a1);
      prs_host_model_i.xfer(d, q, a2);
      prs_host_model_i.stop();
      chk("write acks", 16'h0000, {13'h0, a0, a1, a2});
      chk("write pulses", 16'h0001, 16'(n_wr - n0));
      chk("write word", {idx, d}, last_wr);
   endtask : t_write
   task automatic t_read(input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk);
      rd_data <= d;
      n0 = n_rd;
      prs_host_model_i.start();
      prs_host_model_i.xfer(DEV_RD_ID, q, a0);
      prs_host_model_i.xfer(8'hff, q, a1);
      prs_host_model_i.stop();
      chk("read ack and nack", 16'h0001, {14'h0, a0, a1});
      chk("read byte", {8'h00, d}, {8'h00, q});
      chk("read index", {8'h01, idx}, {8'(n_rd - n0), last_idx});
   endtask : t_read
   task automatic t_refuse();
      @(posedge clk);
      n0 = n_wr;
      prs_host_model_i.start();
      prs_host_model_i.xfer(8'hdc, q, a0);
      prs_host_model_i.xfer(8'h11, q, a1);
      prs_host_model_i.stop();
      chk("foreign acks", 16'h0003, {14'h0, a0, a1});
      prs_host_model_i.start();
      prs_host_model_i.xfer(DEV_WR_ID, q, a0);
      prs_host_model_i.xfer(8'h21, q, a1);
      prs_host_model_i.xfer(8'h42, q, a2);
      prs_host_model_i.xfer(8'h99, q, a3);
      prs_host_model_i.stop();
      chk("extra byte ack", 16'h0001, {12'h0, a0, a1, a2, a3});
      chk("extra pulses", 16'h0001, 16'(n_wr - n0));
      chk("extra word", 16'h2142, last_wr);
   endtask : t_refuse
   task automatic t_spike();
      @(posedge clk);
      prs_host_model_i.spike();
      repeat (20) @(posedge clk);
      chk("spike frame", 16'h0000, {15'h0, frame_active});
      prs_host_model_i.idle();
   endtask : t_spike
   // main sequence; a bus clock of 160 ns stands for the link rate
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      t_spike();
      t_write(8'h1f, 8'h03);
      t_write(8'h1e, 8'ha6);
      t_read(8'h1e, 8'h5a);
      t_refuse();
      t_write(8'h80, 8'h01);
      t_read(8'h80, 8'h81);
      final_report();
   end
   // hang guard
   initial begin
      #200000;
      errors++;
      final_report();
   end
endmodule : prs_i2c_slave_tb_top
`default_nettype wire
